/* core/pmx_glitch_filter.sv */
/*
 one-pin input glitch filter.
 assumes din is already synchronised to clock.
*/
`default_nettype none

module pmx_glitch_filter
  import pmx_pkg::*;
#(
  parameter int CYC = GLITCH_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic ce,
  input wire logic rst_n,
  // filter
  input wire logic en,
  input wire logic din,
  output logic dout
);

  localparam int CNT_W = $clog2(CYC + 1);

  logic out_r, out_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;

  // ==========================================================
  // accept a new level only after it held for CYC samples
  always_comb begin
    out_nxt = out_r;
    cnt_nxt = '0;
    if (!en) begin
      out_nxt = din;
    end else if (din != out_r) begin
      if (cnt_r == CNT_W'(CYC - 1)) begin
        out_nxt = din;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= FILT_OUT_RST;
      cnt_r <= '0;
    end else if (ce) begin
      out_r <= out_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign dout = out_r;

  property p_filter_hold;
    @(posedge clock) disable iff (!rst_n)
    $changed(out_r) && $past(en) |->
      out_r == $past(din) && $past(cnt_r) == CNT_W'(CYC - 1);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("filter output changed before input was stable");

endmodule : pmx_glitch_filter

`default_nettype wire

/* core/pmx_pin_mux.sv */
/*
 pin configuration block: per-pin function mux, biasing, open-drain,
 hysteresis, inversion and glitch filter (all but port 0 pin 10), with APB registers.
 assumes pads resolve level from padOut/padOe and peripherals sit on clock.
*/
// Implementation choices: register access over APB and the register addresses.
`default_nettype none

module pmx_pin_mux
  import pmx_pkg::*;
(
  // clock, enable and reset
  input wire logic clock,
  input wire logic ce,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pads
  input wire logic [NUM_PINS-1:0] padIn,
  output logic [NUM_PINS-1:0] padOut,
  output logic [NUM_PINS-1:0] padOe,
  output logic [NUM_PINS-1:0] padPullUp,
  output logic [NUM_PINS-1:0] padPullDown,
  output logic [NUM_PINS-1:0] padRepeater,
  output logic [NUM_PINS-1:0] padHyst,
  output logic [NUM_PINS-1:0] padAnalog,
  // general purpose io
  input wire logic [NUM_PINS-1:0] gpioOut,
  input wire logic [NUM_PINS-1:0] gpioOe,
  output logic [NUM_PINS-1:0] gpioIn,
  // debug
  output logic dbgTck,
  output logic dbgTdi,
  output logic dbgTms,
  output logic dbgTrst,
  input wire logic dbgTdo,
  input wire logic dbgTdoOe,
  input wire logic swdioOut,
  input wire logic swdioOe,
  output logic swdioIn,
  // serial ports
  input wire logic sck0Out,
  input wire logic sck0Oe,
  output logic sck0In,
  input wire logic miso1Out,
  input wire logic miso1Oe,
  output logic miso1In,
  // timers
  input wire logic t16aMatch2,
  input wire logic t16bMatch1,
  input wire logic t32aMatch3,
  input wire logic [3:0] t32bMatch,
  output logic t32bCapture0,
  // adc
  output logic [ADC_CH-1:0] adcSel
);

  // ==========================================================
  // input synchronisers, filters, inversion
  logic [NUM_PINS-1:0] syncA_r, syncB_r, filtered, pinIn;
  logic [FUNCTION_SELECT_FIELD_W-1:0] pinFn [NUM_PINS];
  logic [CFG_W-1:0] cfg_r [NUM_PINS];
  logic [CFG_W-1:0] cfg_nxt [NUM_PINS];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= '0;
      syncB_r <= '0;
    end else if (ce) begin
      syncA_r <= padIn;
      syncB_r <= syncA_r;
    end
  end

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    assign pinFn[g] = cfg_r[g][FUNCTION_SELECT_FIELD_LSB +: FUNCTION_SELECT_FIELD_W];
    if (g >= FIRST_FILT_PIN) begin : g_filt
      pmx_glitch_filter #(.CYC(GLITCH_CYC)) u_filt (
        .clock(clock),
        .ce(ce),
        .rst_n(rst_n),
        .en(cfg_r[g][FILT_BIT]),
        .din(syncB_r[g]),
        .dout(filtered[g])
      );
    end else begin : g_nofilt
      assign filtered[g] = syncB_r[g];
    end
    assign pinIn[g] = filtered[g] ^ cfg_r[g][INV_BIT];
  end

  // ==========================================================
  // apb slave and configuration registers
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [IDX_W-1:0] idx;
  logic cfgHit, statusHit, wrEn;

  assign idx = paddr[IDX_LSB +: IDX_W];
  assign cfgHit =
    (paddr[ADDR_W-1:CFG_SPAN_LSB] == CFG_BASE[ADDR_W-1:CFG_SPAN_LSB])
    && (paddr[IDX_LSB-1:0] == 2'h0) && (idx < IDX_W'(NUM_PINS));
  assign statusHit = (paddr == STATUS_OFF);
  assign wrEn = psel && penable && pready_r && pwrite && cfgHit;

  always_comb begin
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      cfg_nxt[i] = cfg_r[i];
      if (wrEn && idx == IDX_W'(i)) begin
        cfg_nxt[i] = pwdata[CFG_W-1:0] & cfgMask(i);
      end
    end
    if (psel && !penable) begin
      pready_nxt = 1'b1;
      pslverr_nxt = !(cfgHit || statusHit);
      prdata_nxt = '0;
      if (cfgHit && !pwrite) begin
        prdata_nxt = {{(32 - CFG_W){1'b0}}, cfg_r[idx]};
      end else if (statusHit && !pwrite) begin
        prdata_nxt = {{(32 - NUM_PINS){1'b0}}, pinIn};
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      for (int i = 0; i < NUM_PINS; i++) begin
        cfg_r[i] <= cfgReset(i);
      end
    end else if (ce) begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      for (int i = 0; i < NUM_PINS; i++) begin
        cfg_r[i] <= cfg_nxt[i];
      end
    end
  end

  // ==========================================================
  // function multiplexer
  logic [NUM_PINS-1:0] dOut, dOe, ana;
  logic [NUM_PINS-1:0] padOut_r, padOe_r, padPullUp_r, padPullDown_r;
  logic [NUM_PINS-1:0] padRepeater_r, padHyst_r, padAnalog_r, gpioIn_r;
  logic [NUM_PINS-1:0] padOut_nxt, padOe_nxt, padPullUp_nxt;
  logic [NUM_PINS-1:0] padPullDown_nxt, padRepeater_nxt, padHyst_nxt;
  logic [NUM_PINS-1:0] padAnalog_nxt, gpioIn_nxt;
  logic [7:0] periIn_r, periIn_nxt;
  logic [ADC_CH-1:0] adcSel_r;
  logic od;
  logic [MODE_W-1:0] mode;

  always_comb begin
    od = 1'b0;
    mode = MODE_NONE;
    for (int i = 0; i < NUM_PINS; i++) begin
      dOut[i] = 1'b0;
      dOe[i] = 1'b0;
      ana[i] = 1'b0;
      if (pinFn[i] == FN_GPIO
          || (pinFn[i] == FN_DEFAULT && i >= FIRST_GPIO_PIN)) begin
        dOut[i] = gpioOut[i];
        dOe[i] = gpioOe[i];
      end
      if (pinFn[i] == FN_ALT1 && i >= FIRST_AD_PIN) begin
        ana[i] = 1'b1;
      end
    end
    // only listed candidate pins get each signal
    if (pinFn[PIN_P0_10] == FN_ALT1) begin
      dOut[PIN_P0_10] = sck0Out;
      dOe[PIN_P0_10] = sck0Oe;
    end
    if (pinFn[PIN_P0_10] == FN_ALT2) begin
      dOut[PIN_P0_10] = t16aMatch2;
      dOe[PIN_P0_10] = 1'b1;
    end
    if (pinFn[PIN_P0_11] == FN_ALT2) begin
      dOut[PIN_P0_11] = t32aMatch3;
      dOe[PIN_P0_11] = 1'b1;
    end
    if (pinFn[PIN_P0_13] == FN_DEFAULT) begin
      dOut[PIN_P0_13] = dbgTdo;
      dOe[PIN_P0_13] = dbgTdoOe;
    end
    for (int k = 0; k < 4; k++) begin
      if (pinFn[PIN_P0_13 + k] == FN_ALT2) begin
        dOut[PIN_P0_13 + k] = t32bMatch[k];
        dOe[PIN_P0_13 + k] = 1'b1;
      end
    end
    if (pinFn[PIN_P0_15] == FN_DEFAULT) begin
      dOut[PIN_P0_15] = swdioOut;
      dOe[PIN_P0_15] = swdioOe;
    end
    if (pinFn[PIN_P0_22] == FN_ALT2) begin
      dOut[PIN_P0_22] = t16bMatch1;
      dOe[PIN_P0_22] = 1'b1;
    end
    if (pinFn[PIN_P0_22] == FN_ALT3) begin
      dOut[PIN_P0_22] = miso1Out;
      dOe[PIN_P0_22] = miso1Oe;
    end
    // pin to peripheral; unrouted inputs rest at zero
    periIn_nxt[0] = (pinFn[PIN_P0_10] == FN_DEFAULT) && pinIn[PIN_P0_10];
    periIn_nxt[1] = (pinFn[PIN_P0_11] == FN_DEFAULT) && pinIn[PIN_P0_11];
    periIn_nxt[2] = (pinFn[PIN_P0_12] == FN_DEFAULT) && pinIn[PIN_P0_12];
    periIn_nxt[3] = (pinFn[PIN_P0_14] == FN_DEFAULT) && pinIn[PIN_P0_14];
    periIn_nxt[4] = (pinFn[PIN_P0_15] == FN_DEFAULT) && pinIn[PIN_P0_15];
    periIn_nxt[5] = (pinFn[PIN_P0_10] == FN_ALT1)
      && pinIn[PIN_P0_10];
    periIn_nxt[6] = (pinFn[PIN_P0_22] == FN_ALT3) && pinIn[PIN_P0_22];
    periIn_nxt[7] = (pinFn[PIN_P0_12] == FN_ALT2) && pinIn[PIN_P0_12];
    // pad controls
    for (int i = 0; i < NUM_PINS; i++) begin
      od = cfg_r[i][OD_BIT];
      mode = cfg_r[i][MODE_LSB +: MODE_W];
      padOut_nxt[i] = od ? 1'b0 : dOut[i];
      padOe_nxt[i] = ana[i] ? 1'b0 : (od ? (dOe[i] && !dOut[i]) : dOe[i]);
      padPullUp_nxt[i] = (mode == MODE_UP);
      padPullDown_nxt[i] = (mode == MODE_DOWN);
      padRepeater_nxt[i] = (mode == MODE_REPEAT);
      padHyst_nxt[i] = cfg_r[i][HYS_BIT];
      padAnalog_nxt[i] = ana[i];
      gpioIn_nxt[i] = ana[i] ? 1'b0 : pinIn[i];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      padOut_r <= '0;
      padOe_r <= '0;
      padPullUp_r <= '0;
      padPullDown_r <= '0;
      padRepeater_r <= '0;
      padHyst_r <= '0;
      padAnalog_r <= '0;
      gpioIn_r <= '0;
      periIn_r <= '0;
      adcSel_r <= '0;
    end else if (ce) begin
      padOut_r <= padOut_nxt;
      padOe_r <= padOe_nxt;
      padPullUp_r <= padPullUp_nxt;
      padPullDown_r <= padPullDown_nxt;
      padRepeater_r <= padRepeater_nxt;
      padHyst_r <= padHyst_nxt;
      padAnalog_r <= padAnalog_nxt;
      gpioIn_r <= gpioIn_nxt;
      periIn_r <= periIn_nxt;
      adcSel_r <= padAnalog_nxt[NUM_PINS-1:FIRST_AD_PIN];
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign padOut = padOut_r;
  assign padOe = padOe_r;
  assign padPullUp = padPullUp_r;
  assign padPullDown = padPullDown_r;
  assign padRepeater = padRepeater_r;
  assign padHyst = padHyst_r;
  assign padAnalog = padAnalog_r;
  assign gpioIn = gpioIn_r;
  assign dbgTck = periIn_r[0];
  assign dbgTdi = periIn_r[1];
  assign dbgTms = periIn_r[2];
  assign dbgTrst = periIn_r[3];
  assign swdioIn = periIn_r[4];
  assign sck0In = periIn_r[5];
  assign miso1In = periIn_r[6];
  assign t32bCapture0 = periIn_r[7];
  assign adcSel = adcSel_r;

  // ==========================================================
  // assertions
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_pin3;
    s_setup ##1 (psel && penable && pready && pwrite && ce
      && paddr == ADDR_W'(PIN_P0_13 * 4));
  endsequence

  property p_write_cfg;
    @(posedge clock) disable iff (!rst_n)
    s_wr_pin3 |=> cfg_r[PIN_P0_13] == ($past(pwdata[CFG_W-1:0]) & CFG_MASK);
  endproperty
  a_write_cfg: assert property (p_write_cfg)
    else $error("configuration write not stored");

  property p_route_tdo;
    @(posedge clock) disable iff (!rst_n)
    ce && pinFn[PIN_P0_13] == FN_DEFAULT && !cfg_r[PIN_P0_13][OD_BIT]
      |=> padOut_r[PIN_P0_13] == $past(dbgTdo)
        && padOe_r[PIN_P0_13] == $past(dbgTdoOe);
  endproperty
  a_route_tdo: assert property (p_route_tdo)
    else $error("debug output not on its pin");

  property p_unrouted_sck0;
    @(posedge clock) disable iff (!rst_n)
    ce && pinFn[PIN_P0_10] != FN_ALT1 |=> !sck0In;
  endproperty
  a_unrouted_sck0: assert property (p_unrouted_sck0)
    else $error("unrouted serial clock input moved");

  property p_pull_mode;
    @(posedge clock) disable iff (!rst_n)
    ce && cfg_r[PIN_P0_11][MODE_LSB +: MODE_W] == MODE_DOWN
      |=> padPullDown_r[PIN_P0_11] && !padPullUp_r[PIN_P0_11]
        && !padRepeater_r[PIN_P0_11];
  endproperty
  a_pull_mode: assert property (p_pull_mode)
    else $error("bias mode wrong");

  property p_open_drain;
    @(posedge clock) disable iff (!rst_n)
    ce && cfg_r[PIN_P0_16][OD_BIT] |=> !padOut_r[PIN_P0_16];
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin drove high");

  property p_filter_reset;
    @(posedge clock)
    $rose(rst_n) |-> cfg_r[PIN_P0_11][FILT_BIT] && cfg_r[PIN_P0_23][FILT_BIT]
      && !cfg_r[PIN_P0_10][FILT_BIT];
  endproperty
  a_filter_reset: assert property (p_filter_reset)
    else $error("glitch filter not on after reset");

  property p_reset_debug;
    @(posedge clock)
    $rose(rst_n) |-> pinFn[PIN_P0_10] == FN_DEFAULT
      && pinFn[PIN_P0_15] == FN_DEFAULT && !padOe_r[PIN_P0_13];
  endproperty
  a_reset_debug: assert property (p_reset_debug)
    else $error("debug function not selected after reset");

  property p_analog_iso;
    @(posedge clock) disable iff (!rst_n)
    ce && pinFn[PIN_P0_22] == FN_ALT1 |=> padAnalog_r[PIN_P0_22]
      && !padOe_r[PIN_P0_22] && !gpioIn_r[PIN_P0_22] && adcSel_r[6];
  endproperty
  a_analog_iso: assert property (p_analog_iso)
    else $error("analog pin still digital");

endmodule : pmx_pin_mux

`default_nettype wire

/* core/pmx_pkg.sv */
/*
 pin configuration and function multiplexer: shared constants.
 assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
// Behaviour
// - each pin's configuration register picks exactly one peripheral function for it
// - an enabled peripheral without a routed pin has no guaranteed pin-side activity
// - each pin offers pull-up, pull-down or repeater biasing
// - each pin offers pseudo open-drain output: drives low, releases instead of high
// - the eight analog-capable pins have a 10 ns glitch filter, on after reset
// - after reset only the debug functions are selected on their pins; the code also selects GPIO on port 0 pins 16, 22 and 23
`default_nettype none

package pmx_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_PINS = 9;
  localparam int ADDR_W = 12;
  localparam int CFG_W = 11;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 4;
  localparam int CFG_SPAN_LSB = 6;
  localparam int ADC_CH = 8;

  // ==========================================================
  // pin indices (port 0 pins 10..16, 22, 23)
  localparam int PIN_P0_10 = 0;
  localparam int PIN_P0_11 = 1;
  localparam int PIN_P0_12 = 2;
  localparam int PIN_P0_13 = 3;
  localparam int PIN_P0_14 = 4;
  localparam int PIN_P0_15 = 5;
  localparam int PIN_P0_16 = 6;
  localparam int PIN_P0_22 = 7;
  localparam int PIN_P0_23 = 8;
  localparam int FIRST_AD_PIN = 1;
  localparam int FIRST_GPIO_PIN = 6;
  localparam int FIRST_FILT_PIN = 1;

  // ==========================================================
  // configuration register fields
  localparam int FUNCTION_SELECT_FIELD_LSB = 0;
  localparam int FUNCTION_SELECT_FIELD_W = 3;
  localparam int MODE_LSB = 3;
  localparam int MODE_W = 2;
  localparam int HYS_BIT = 5;
  localparam int INV_BIT = 6;
  localparam int FILT_BIT = 8;
  localparam int OD_BIT = 10;

  localparam logic [FUNCTION_SELECT_FIELD_W-1:0] FN_DEFAULT = 3'h0;
  localparam logic [FUNCTION_SELECT_FIELD_W-1:0] FN_GPIO = 3'h1;
  localparam logic [FUNCTION_SELECT_FIELD_W-1:0] FN_ALT1 = 3'h2;
  localparam logic [FUNCTION_SELECT_FIELD_W-1:0] FN_ALT2 = 3'h3;
  localparam logic [FUNCTION_SELECT_FIELD_W-1:0] FN_ALT3 = 3'h4;

  localparam logic [MODE_W-1:0] MODE_NONE = 2'h0;
  localparam logic [MODE_W-1:0] MODE_DOWN = 2'h1;
  localparam logic [MODE_W-1:0] MODE_UP = 2'h2;
  localparam logic [MODE_W-1:0] MODE_REPEAT = 2'h3;

  localparam logic [CFG_W-1:0] CFG_MASK = 11'h57f;
  localparam logic [CFG_W-1:0] CFG_MASK_NOFILT = 11'h47f;
  localparam logic [CFG_W-1:0] CFG_RST = 11'h110;
  localparam logic [CFG_W-1:0] CFG_RST_NOFILT = 11'h010;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] CFG_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h040;

  // ==========================================================
  // timing
  localparam int GLITCH_NS = 10;
  localparam int CLK_PERIOD_NS = 50;
  localparam int GLITCH_RAW = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CYC = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;
  localparam logic FILT_OUT_RST = 1'b0;

  function automatic logic [CFG_W-1:0] cfgMask(input int i);
    return (i >= FIRST_FILT_PIN) ? CFG_MASK : CFG_MASK_NOFILT;
  endfunction : cfgMask

  function automatic logic [CFG_W-1:0] cfgReset(input int i);
    return (i >= FIRST_FILT_PIN) ? CFG_RST : CFG_RST_NOFILT;
  endfunction : cfgReset

endpackage : pmx_pkg

`default_nettype wire

/* tb/pin_function_mux_config_bench.sv */
/*
 self-checking bench for the pin configuration block.
 assumes zero-wait APB answers and pad outputs two edges after a write.
*/
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module pin_function_mux_config_bench
  import pmx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // signals
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [NUM_PINS-1:0] padIn, padOut, padOe, padPullUp, padPullDown;
  logic [NUM_PINS-1:0] padRepeater, padHyst, padAnalog, gpioIn;
  logic [NUM_PINS-1:0] gpioOut = '0, gpioOe = '0, extVal = '0, extEn = '0;
  logic dbgTck, dbgTdi, dbgTms, dbgTrst, swdioIn, sck0In, miso1In, capIn;
  logic [14:0] prf = '0;
  logic [ADC_CH-1:0] adcSel;
  logic [32:0] expQ[$];
  logic [32:0] e;
  logic [CFG_W-1:0] v;
  int mismatches = 0, compares = 0, cycles = 0;

  initial forever #25 clock = ~clock;

  // ==========================================================
  // design and pads
  pmx_pin_mux uut (.clock(clock), .ce(ce), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .padPullUp(padPullUp),
    .padPullDown(padPullDown), .padRepeater(padRepeater), .padHyst(padHyst),
    .padAnalog(padAnalog), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .gpioIn(gpioIn), .dbgTck(dbgTck), .dbgTdi(dbgTdi), .dbgTms(dbgTms),
    .dbgTrst(dbgTrst), .dbgTdo(prf[0]), .dbgTdoOe(prf[1]),
    .swdioOut(prf[2]), .swdioOe(prf[3]), .swdioIn(swdioIn),
    .sck0Out(prf[4]), .sck0Oe(prf[5]), .sck0In(sck0In),
    .miso1Out(prf[6]), .miso1Oe(prf[7]), .miso1In(miso1In),
    .t16aMatch2(prf[8]), .t16bMatch1(prf[9]), .t32aMatch3(prf[10]),
    .t32bMatch(prf[14:11]), .t32bCapture0(capIn), .adcSel(adcSel));

  pmx_pad_model pads (.clock(clock), .padOut(padOut), .padOe(padOe),
    .padPullUp(padPullUp), .padPullDown(padPullDown), .extVal(extVal),
    .extEn(extEn), .padIn(padIn));

  // ==========================================================
  // apb master
  task automatic apbXfer(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apbXfer

  task automatic apbRead(input logic [ADDR_W-1:0] a, input logic [32:0] x);
    expQ.push_back(x);
    apbXfer(1'b0, a, 32'h0);
  endtask : apbRead

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
  endtask : settle

  // read results are taken off the note queue as they appear
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
    begin
      e = expQ.pop_front();
      `CHK({pslverr, prdata}, e)
    end
  end

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ==========================================================
  // tests
  initial begin
    void'($urandom(47));
    settle(2);
    rst_n <= 1'b1;
    settle(2);
    `CHK(padPullUp, 9'h1ff)
    for (int i = 0; i < NUM_PINS; i++) begin
      apbRead(12'(4 * i),
              {1'b0, 21'h0, (i == 0) ? 11'h010 : 11'h110});
    end
    prf <= 15'($urandom);
    extVal <= 9'($urandom);
    extEn <= 9'h017;
    settle(6);
    `CHK({dbgTrst, dbgTms, dbgTdi, dbgTck}, {extVal[4], extVal[2:0]})
    `CHK({padOe[3], padOut[3]}, {prf[1], prf[0]})
    $display("test reset_defaults done");

    extEn <= '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      v = 11'($urandom);
      apbXfer(1'b1, 12'(4 * i), {21'h0, v});
      apbRead(12'(4 * i),
              {1'b0, 21'h0, v & ((i == 0) ? 11'h47f : 11'h57f)});
    end
    apbXfer(1'b1, 12'h044, 32'hffff_ffff);
    apbRead(12'h044, {1'b1, 32'h0});
    // back to reset configuration before routing tests
    for (int i = 0; i < NUM_PINS; i++) begin
      apbXfer(1'b1, 12'(4 * i), (i == 0) ? 32'h010 : 32'h110);
    end
    $display("test register_access done");

    apbXfer(1'b1, 12'h000, 32'h003);
    apbXfer(1'b1, 12'h004, 32'h102);
    prf <= 15'($urandom);
    settle(6);
    `CHK({padOe[0], padOut[0]}, {1'b1, prf[8]})
    `CHK(dbgTck, 1'b0)
    `CHK({adcSel, padAnalog[1], padOe[1]}, {8'h01, 1'b1, 1'b0})
    $display("test function_routing done");

    for (int m = 0; m < 4; m++) begin
      apbXfer(1'b1, 12'h018, {26'h0, m[0], 2'(m), 3'h1});
      settle(3);
      `CHK({padRepeater[6], padPullUp[6], padPullDown[6]}, 3'(m == 3 ? 4 : m))
      `CHK(padHyst[6], m[0])
    end
    $display("test bias_modes done");

    apbXfer(1'b1, 12'h018, 32'h401);
    gpioOe[6] <= 1'b1;
    for (int d = 0; d < 2; d++) begin
      gpioOut[6] <= d[0];
      settle(3);
      `CHK({padOe[6], padOut[6]}, {~d[0], 1'b0})
    end
    apbXfer(1'b1, 12'h018, 32'h001);
    gpioOut[6] <= 1'($urandom);
    settle(3);
    `CHK({padOe[6], padOut[6]}, {1'b1, gpioOut[6]})
    ce <= 1'b0;
    gpioOut[6] <= ~gpioOut[6];
    settle(3);
    `CHK(padOut[6], ~gpioOut[6])
    ce <= 1'b1;
    settle(3);
    `CHK(padOut[6], gpioOut[6])
    $display("test open_drain done");

    apbXfer(1'b1, 12'h01c, 32'h151);
    extEn[7] <= 1'b1;
    for (int d = 0; d < 2; d++) begin
      extVal[7] <= d[0];
      settle(6);
      `CHK(gpioIn[7], ~d[0])
    end
    $display("test input_invert done");
    settle(2);
    give_verdict();
  end
endmodule : pin_function_mux_config_bench

`default_nettype wire

/* tb/pmx_pad_model.sv */
/*
 pad and board model: resolves each pin level from the block's drive,
 its pulls and an external driver set by the bench.
 assumes the bench never drives a pin the block also drives.
*/
`default_nettype none

module pmx_pad_model
  import pmx_pkg::*;
(
  // clock
  input wire logic clock,
  // block side
  input wire logic [NUM_PINS-1:0] padOut,
  input wire logic [NUM_PINS-1:0] padOe,
  input wire logic [NUM_PINS-1:0] padPullUp,
  input wire logic [NUM_PINS-1:0] padPullDown,
  // board side
  input wire logic [NUM_PINS-1:0] extVal,
  input wire logic [NUM_PINS-1:0] extEn,
  output logic [NUM_PINS-1:0] padIn
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // level resolution
  logic floatLvl = 1'b0;

  // an undriven, unpulled pin wanders every cycle
  always @(posedge clock) begin
    floatLvl <= ~floatLvl;
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (extEn[i]) begin
        padIn[i] = extVal[i];
      end else if (padOe[i]) begin
        padIn[i] = padOut[i];
      end else if (padPullUp[i]) begin
        padIn[i] = 1'b1;
      end else if (padPullDown[i]) begin
        padIn[i] = 1'b0;
      end else begin
        padIn[i] = floatLvl;
      end
    end
  end
endmodule : pmx_pad_model

`default_nettype wire
